// ### hw/pcss_pkg.sv
package pcss_pkg;

    // ----------------------------------------
    // Serial framing
    // ----------------------------------------
    localparam logic [6:0] SLAVE_ADDR   = 7'h65;
    localparam logic [3:0] BYTE_BITS    = 4'h8;
    localparam logic [2:0] IDX_DIVIDER_CONTROL_BYTE    = 3'h2;  // After two dummy bytes
    localparam logic [2:0] IDX_FEEDBACK_COUNT_BYTE    = 3'h3;
    localparam logic [2:0] IDX_RESERVED_BYTE    = 3'h4;
    localparam logic [2:0] IDX_EXTRA    = 3'h5;
    localparam logic [1:0] RD_IDX_LAST  = 2'h3;

    // ----------------------------------------
    // Divider control byte layout and resets
    // ----------------------------------------
    localparam int         QBYP_BIT     = 7;
    localparam int         PSEL_BIT     = 6;
    localparam int         QCNT_MSB     = 5;
    localparam logic [7:0] CTRL_RESET   = 8'h00;
    localparam logic [7:0] FB_RESET     = 8'h00;
    localparam logic [7:0] RSVD_RESET   = 8'h00;
    localparam logic [7:0] RD_FILL      = 8'h00;
    localparam logic [3:0] PIN_IDLE     = 4'h7;  // Select low; multiplier, data, clock high

    // ----------------------------------------
    // Divisor arithmetic
    // ----------------------------------------
    localparam logic [9:0] FB_OFFSET    = 10'h003;
    localparam logic [6:0] REF_OFFSET   = 7'h02;
    localparam logic [6:0] REF_BYP_DIV  = 7'h01;
    localparam logic [9:0] PIN_MULT_LO  = 10'h010;  // Pin low: x16
    localparam logic [9:0] PIN_MULT_HI  = 10'h008;  // Pin high: x8

    // ----------------------------------------
    // Power-up settling
    // ----------------------------------------
    localparam int unsigned SETTLE_TIME_MS = 3;
    localparam int unsigned CLK_FREQ_HZ    = 200000000;
    localparam int unsigned SETTLE_CYCLES  = SETTLE_TIME_MS * (CLK_FREQ_HZ / 1000);
    localparam int          SETTLE_CNT_W   = 20;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_BYTE,
        ST_WR_ACK,
        ST_RD_BYTE,
        ST_RD_ACK,
        ST_IGNORE
    } pcss_state_t;

endpackage : pcss_pkg

// ### hw/pcss_sync.sv
module pcss_sync #(
    parameter int           W       = 4,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    // ----------------------------------------
    // Two-stage synchroniser, one per bit
    // ----------------------------------------
    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            meta_reg <= RST_VAL;  // Idle level, no false edge at release
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;

endmodule : pcss_sync

// ### hw/pcss_settle.sv
module pcss_settle #(
    parameter int unsigned CYCLES = pcss_pkg::SETTLE_CYCLES
) (
    input  wire logic i_clk,
    input  wire logic i_sys_rst,
    output logic      o_done
);

    localparam int W = pcss_pkg::SETTLE_CNT_W;

    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic         done_reg;
    logic         done_next;

    // ----------------------------------------
    // Count from reset release to settled
    // ----------------------------------------
    always_comb begin
        cnt_next  = cnt_reg;
        done_next = done_reg;
        if (!done_reg) begin
            if (cnt_reg == W'(CYCLES - 1)) begin
                done_next = 1'b1;
            end else begin
                cnt_next = cnt_reg + W'(1);
            end
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cnt_reg  <= '0;
            done_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            done_reg <= done_next;
        end
    end

    assign o_done = done_reg;

endmodule : pcss_settle

// ### hw/pcss_top.sv
module pcss_top #(
    parameter int unsigned P_SETTLE_CYCLES = pcss_pkg::SETTLE_CYCLES
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_serial_clock_pin,
    input  wire logic       i_serial_data_pin,
    output logic            o_serial_data_pin,
    output logic            o_serial_data_oe_n,
    input  wire logic       i_pll_mult_pin,
    input  wire logic       i_clk_sel_pin,
    output logic [9:0]      o_fb_divisor,
    output logic [6:0]      o_ref_divisor,
    output logic            o_programmed_mode,
    output logic            o_pll_bypass,
    output logic            o_clocks_settled
);

    // ----------------------------------------
    // Pin synchronisation
    // ----------------------------------------
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic       mult_s;
    logic       csel_s;

    pcss_sync #(
        .W       (4),
        .RST_VAL (pcss_pkg::PIN_IDLE)
    ) u_sync (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   ({i_clk_sel_pin, i_pll_mult_pin, i_serial_data_pin, i_serial_clock_pin}),
        .o_sync    (pins_s)
    );

    assign scl_s  = pins_s[0];
    assign sda_s  = pins_s[1];
    assign mult_s = pins_s[2];
    assign csel_s = pins_s[3];

    // ----------------------------------------
    // Edge and condition detection
    // ----------------------------------------
    logic scl_q_reg;
    logic scl_q_next;
    logic sda_q_reg;
    logic sda_q_next;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    // Previous line levels
    always_comb begin
        scl_q_next = scl_s;
        sda_q_next = sda_s;
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            scl_q_reg <= 1'b1;
            sda_q_reg <= 1'b1;
        end else begin
            scl_q_reg <= scl_q_next;
            sda_q_reg <= sda_q_next;
        end
    end

    // Data edges while clock high frame a transfer
    assign scl_rise  = scl_s & ~scl_q_reg;
    assign scl_fall  = ~scl_s & scl_q_reg;
    assign start_det = scl_s & scl_q_reg & sda_q_reg & ~sda_s;
    assign stop_det  = scl_s & scl_q_reg & ~sda_q_reg & sda_s;

    // ----------------------------------------
    // Serial slave state machine
    // ----------------------------------------
    pcss_pkg::pcss_state_t state_reg;
    pcss_pkg::pcss_state_t state_next;
    logic [3:0]            bit_cnt_reg;
    logic [3:0]            bit_cnt_next;
    logic [7:0]            shift_reg;
    logic [7:0]            shift_next;
    logic [2:0]            byte_idx_reg;
    logic [2:0]            byte_idx_next;
    logic [1:0]            rd_idx_reg;
    logic [1:0]            rd_idx_next;
    logic                  nack_reg;
    logic                  nack_next;
    logic                  oe_n_reg;
    logic                  oe_n_next;
    logic                  wr_strobe;
    logic [7:0]            rd_byte;

    logic [7:0]            ctrl_reg;
    logic [7:0]            fb_reg;
    logic [7:0]            rsvd_reg;

    // Byte returned to a reading master
    always_comb begin
        case (rd_idx_reg)
            2'h0:    rd_byte = ctrl_reg;
            2'h1:    rd_byte = fb_reg;
            2'h2:    rd_byte = rsvd_reg;
            default: rd_byte = pcss_pkg::RD_FILL;
        endcase
    end

    // Next state of the slave
    always_comb begin
        state_next    = state_reg;
        bit_cnt_next  = bit_cnt_reg;
        shift_next    = shift_reg;
        byte_idx_next = byte_idx_reg;
        rd_idx_next   = rd_idx_reg;
        nack_next     = nack_reg;
        oe_n_next     = oe_n_reg;
        wr_strobe     = 1'b0;
        if (stop_det) begin
            state_next = pcss_pkg::ST_IDLE;
            oe_n_next  = 1'b1;
        end else if (start_det) begin
            state_next   = pcss_pkg::ST_ADDR;
            bit_cnt_next = 4'h0;
            oe_n_next    = 1'b1;
        end else begin
            case (state_reg)
                pcss_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == pcss_pkg::BYTE_BITS) begin
                        if (shift_reg[7:1] == pcss_pkg::SLAVE_ADDR) begin
                            oe_n_next     = 1'b0;
                            state_next    = pcss_pkg::ST_ADDR_ACK;
                            byte_idx_next = 3'h0;
                            rd_idx_next   = 2'h0;
                        end else begin
                            state_next = pcss_pkg::ST_IGNORE;
                        end
                    end
                end
                pcss_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        bit_cnt_next = 4'h0;
                        if (shift_reg[0]) begin
                            state_next  = pcss_pkg::ST_RD_BYTE;
                            shift_next  = rd_byte;
                            oe_n_next   = rd_byte[7];
                            rd_idx_next = rd_idx_reg + 2'h1;
                        end else begin
                            state_next = pcss_pkg::ST_WR_BYTE;
                            oe_n_next  = 1'b1;
                        end
                    end
                end
                pcss_pkg::ST_WR_BYTE: begin
                    if (scl_rise) begin
                        shift_next   = {shift_reg[6:0], sda_s};
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall && bit_cnt_reg == pcss_pkg::BYTE_BITS) begin
                        wr_strobe  = 1'b1;
                        oe_n_next  = 1'b0;
                        state_next = pcss_pkg::ST_WR_ACK;
                        if (byte_idx_reg != pcss_pkg::IDX_EXTRA) begin
                            byte_idx_next = byte_idx_reg + 3'h1;
                        end
                    end
                end
                pcss_pkg::ST_WR_ACK: begin
                    if (scl_fall) begin
                        oe_n_next    = 1'b1;
                        bit_cnt_next = 4'h0;
                        state_next   = pcss_pkg::ST_WR_BYTE;
                    end
                end
                pcss_pkg::ST_RD_BYTE: begin
                    if (scl_rise) begin
                        bit_cnt_next = bit_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (bit_cnt_reg == pcss_pkg::BYTE_BITS) begin
                            oe_n_next  = 1'b1;
                            state_next = pcss_pkg::ST_RD_ACK;
                        end else begin
                            shift_next = {shift_reg[6:0], 1'b0};
                            oe_n_next  = shift_reg[6];
                        end
                    end
                end
                pcss_pkg::ST_RD_ACK: begin
                    if (scl_rise) begin
                        nack_next = sda_s;
                    end else if (scl_fall) begin
                        if (nack_reg) begin
                            state_next = pcss_pkg::ST_IGNORE;
                        end else begin
                            state_next   = pcss_pkg::ST_RD_BYTE;
                            bit_cnt_next = 4'h0;
                            shift_next   = rd_byte;
                            oe_n_next    = rd_byte[7];
                            if (rd_idx_reg != pcss_pkg::RD_IDX_LAST) begin
                                rd_idx_next = rd_idx_reg + 2'h1;
                            end
                        end
                    end
                end
                pcss_pkg::ST_IDLE, pcss_pkg::ST_IGNORE: begin
                    oe_n_next = 1'b1;
                end
                default: begin
                    state_next = pcss_pkg::ST_IDLE;
                    oe_n_next  = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            state_reg    <= pcss_pkg::ST_IDLE;
            bit_cnt_reg  <= 4'h0;
            shift_reg    <= 8'h00;
            byte_idx_reg <= 3'h0;
            rd_idx_reg   <= 2'h0;
            nack_reg     <= 1'b0;
            oe_n_reg     <= 1'b1;
        end else begin
            state_reg    <= state_next;
            bit_cnt_reg  <= bit_cnt_next;
            shift_reg    <= shift_next;
            byte_idx_reg <= byte_idx_next;
            rd_idx_reg   <= rd_idx_next;
            nack_reg     <= nack_next;
            oe_n_reg     <= oe_n_next;
        end
    end

    // ----------------------------------------
    // Latch bytes
    // ----------------------------------------
    logic [7:0] ctrl_next;
    logic [7:0] fb_next;
    logic [7:0] rsvd_next;

    // Dummy and extra bytes fall through
    always_comb begin
        ctrl_next = ctrl_reg;
        fb_next   = fb_reg;
        rsvd_next = rsvd_reg;
        if (wr_strobe) begin
            case (byte_idx_reg)
                pcss_pkg::IDX_DIVIDER_CONTROL_BYTE: ctrl_next = shift_reg;
                pcss_pkg::IDX_FEEDBACK_COUNT_BYTE: fb_next   = shift_reg;
                pcss_pkg::IDX_RESERVED_BYTE: rsvd_next = shift_reg;
                default:             ctrl_next = ctrl_reg;
            endcase
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            ctrl_reg <= pcss_pkg::CTRL_RESET;
            fb_reg   <= pcss_pkg::FB_RESET;
            rsvd_reg <= pcss_pkg::RSVD_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            fb_reg   <= fb_next;
            rsvd_reg <= rsvd_next;
        end
    end

    // ----------------------------------------
    // Divisor selection
    // ----------------------------------------
    logic [9:0] fb_div_reg;
    logic [9:0] fb_div_next;
    logic [6:0] ref_div_reg;
    logic [6:0] ref_div_next;
    logic       psel_reg;
    logic       psel_next;
    logic       byp_reg;
    logic       byp_next;

    // Effective P and Q driving the PLL
    always_comb begin
        psel_next = ctrl_reg[pcss_pkg::PSEL_BIT];
        byp_next  = csel_s;
        if (ctrl_reg[pcss_pkg::PSEL_BIT]) begin
            fb_div_next = ({2'h0, fb_reg} + pcss_pkg::FB_OFFSET) << 1;
            if (ctrl_reg[pcss_pkg::QBYP_BIT]) begin
                ref_div_next = pcss_pkg::REF_BYP_DIV;
            end else begin
                ref_div_next = {1'b0, ctrl_reg[pcss_pkg::QCNT_MSB:0]} + pcss_pkg::REF_OFFSET;
            end
        end else begin
            fb_div_next  = mult_s ? pcss_pkg::PIN_MULT_HI : pcss_pkg::PIN_MULT_LO;
            ref_div_next = pcss_pkg::REF_BYP_DIV;
        end
    end

    always_ff @(posedge i_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            fb_div_reg  <= pcss_pkg::PIN_MULT_HI;
            ref_div_reg <= pcss_pkg::REF_BYP_DIV;
            psel_reg    <= 1'b0;
            byp_reg     <= 1'b0;
        end else begin
            fb_div_reg  <= fb_div_next;
            ref_div_reg <= ref_div_next;
            psel_reg    <= psel_next;
            byp_reg     <= byp_next;
        end
    end

    // ----------------------------------------
    // Power-up settling
    // ----------------------------------------
    pcss_settle #(
        .CYCLES (P_SETTLE_CYCLES)
    ) u_settle (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .o_done    (o_clocks_settled)
    );

    // Open-drain data: value low, enable carries the bit
    assign o_serial_data_pin  = 1'b0;
    assign o_serial_data_oe_n = oe_n_reg;
    assign o_fb_divisor       = fb_div_reg;
    assign o_ref_divisor      = ref_div_reg;
    assign o_programmed_mode  = psel_reg;
    assign o_pll_bypass       = byp_reg;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    AST_ACK_LOW: assert property (
        ((state_reg == pcss_pkg::ST_ADDR_ACK || state_reg == pcss_pkg::ST_WR_ACK) && scl_s) |-> !oe_n_reg)
        else $error("acknowledge not held low while clock high");

    AST_CHANGE_LOW: assert property (
        ($changed(oe_n_reg) && !$past(start_det) && !$past(stop_det)) |-> $past(scl_fall))
        else $error("data line changed outside clock low");

    AST_ADDR_MATCH: assert property (
        (state_reg == pcss_pkg::ST_ADDR && scl_fall && bit_cnt_reg == pcss_pkg::BYTE_BITS
         && shift_reg[7:1] == pcss_pkg::SLAVE_ADDR && !start_det && !stop_det)
        |=> (!oe_n_reg && state_reg == pcss_pkg::ST_ADDR_ACK))
        else $error("own address not acknowledged");

    AST_FOREIGN: assert property (
        (state_reg == pcss_pkg::ST_IGNORE) |-> ##1 oe_n_reg)
        else $error("data line driven during foreign transfer");

    AST_DUMMY: assert property (
        (wr_strobe && byte_idx_reg < pcss_pkg::IDX_DIVIDER_CONTROL_BYTE) |=> ($stable(ctrl_reg) && $stable(fb_reg)))
        else $error("dummy byte altered latches");

    AST_CTRL_CAUSE: assert property (
        $changed(ctrl_reg) |-> $past(wr_strobe && byte_idx_reg == pcss_pkg::IDX_DIVIDER_CONTROL_BYTE))
        else $error("control byte changed without write");

    AST_FB_FORMULA: assert property (
        (psel_reg && $stable(fb_reg)) |-> (fb_div_reg == (({2'h0, fb_reg} + 10'h003) << 1)))
        else $error("feedback divisor formula wrong");

    AST_REF_BYPASS: assert property (
        (ctrl_reg[pcss_pkg::QBYP_BIT] && ctrl_reg[pcss_pkg::PSEL_BIT]) |=> (ref_div_reg == pcss_pkg::REF_BYP_DIV))
        else $error("reference bypass not forcing one");

    AST_PIN_MULT: assert property (
        (!ctrl_reg[pcss_pkg::PSEL_BIT] && $stable(ctrl_reg)) |=>
        (fb_div_reg == ($past(mult_s) ? 10'h008 : 10'h010)))
        else $error("pin multiplier not applied");

    AST_CLK_SEL: assert property (
        byp_reg == $past(csel_s))
        else $error("clock select not passed to bypass");

endmodule : pcss_top

// ### test/pcss_master.sv
module pcss_master (
    input  wire logic i_dev_data,
    input  wire logic i_dev_oe_n,
    output logic      o_scl,
    output logic      o_sda
);
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Two-wire bus master, 80 ns serial clock
    // ----------------------------------------
    logic sda_drv;

    // Wired-AND of both drivers over the pull-up
    assign o_sda = sda_drv & (i_dev_oe_n | i_dev_data);

    // Bus idles released, clock standing high
    initial begin
        o_scl   = 1'b1;
        sda_drv = 1'b1;
    end

    // Start, also usable as repeated start
    task automatic start_cond;
        #20 sda_drv = 1'b1;
        #20 o_scl = 1'b1;
        #40 sda_drv = 1'b0;
        #40 o_scl = 1'b0;
    endtask : start_cond

    // Stop, then clock stands high
    task automatic stop_cond;
        #20 sda_drv = 1'b0;
        #20 o_scl = 1'b1;
        #40 sda_drv = 1'b1;
        #40;
    endtask : stop_cond

    // One bit: change mid-low, sample at rise
    task automatic bit_io(input logic b, output logic s);
        #20 sda_drv = b;
        #20 o_scl = 1'b1;
        s = o_sda;
        #40 o_scl = 1'b0;
    endtask : bit_io

    // Byte out MSB first, then sample the ack slot
    task automatic wr_byte(input logic [7:0] b, output logic ack_n);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], s);
        end
        bit_io(1'b1, ack_n);
    endtask : wr_byte

    // Byte in MSB first, then drive our ack or nack
    task automatic rd_byte(input logic ack_n, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, b[i]);
        end
        bit_io(ack_n, s);
    endtask : rd_byte

endmodule : pcss_master

// ### test/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    // ----------------------------------------
    // Bench signals and instances
    // ----------------------------------------
    logic       i_clk;
    logic       i_sys_rst;
    logic       i_pll_mult_pin;
    logic       i_clk_sel_pin;
    logic       scl;
    logic       sda;
    logic       dev_data;
    logic       dev_oe_n;
    logic [9:0] fb;
    logic [6:0] rdiv;
    logic       pmode;
    logic       byp;
    logic       settled;
    logic       a;
    logic [7:0] rb;
    int         n_fail;
    int         samples_checked;
    logic [7:0] cfg [4][3];

    pcss_top #(.P_SETTLE_CYCLES(50)) uut (
        .i_clk              (i_clk),
        .i_sys_rst          (i_sys_rst),
        .i_serial_clock_pin (scl),
        .i_serial_data_pin  (sda),
        .o_serial_data_pin  (dev_data),
        .o_serial_data_oe_n (dev_oe_n),
        .i_pll_mult_pin     (i_pll_mult_pin),
        .i_clk_sel_pin      (i_clk_sel_pin),
        .o_fb_divisor       (fb),
        .o_ref_divisor      (rdiv),
        .o_programmed_mode  (pmode),
        .o_pll_bypass       (byp),
        .o_clocks_settled   (settled)
    );

    pcss_master mst (
        .i_dev_data (dev_data),
        .i_dev_oe_n (dev_oe_n),
        .o_scl      (scl),
        .o_sda      (sda)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tally_and_finish;
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : tally_and_finish

    // Value compare, zero-extended to 10 bits
    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk

    // Idle cycles, inputs move 1 ns after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : cyc

    // Address, two dummies, three latches, one extra
    task automatic wr_cfg(input logic [7:0] c, input logic [7:0] p, input logic [7:0] r);
        logic [7:0] sq [7];
        sq = '{8'hca, 8'h00, 8'h00, c, p, r, 8'h3c};
        mst.start_cond();
        for (int i = 0; i < 7; i++) begin
            mst.wr_byte(sq[i], a);
            chk("wr_ack", 10'h000, {9'h000, a});
        end
        mst.stop_cond();
    endtask : wr_cfg

    // Clock generator
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // Watchdog on the whole run
    initial begin
        #100000;
        n_fail++;
        $display("BAD watchdog exp done got hang");
        tally_and_finish();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        i_sys_rst = 1'b1;
        i_pll_mult_pin = 1'b1;
        i_clk_sel_pin = 1'b0;
        n_fail = 0;
        samples_checked = 0;
        cfg = '{'{8'h45, 8'h10, 8'ha5}, '{8'h7f, 8'hff, 8'h11},
                '{8'hc0, 8'h00, 8'h22}, '{8'h05, 8'h20, 8'h5a}};
        cyc(2);
        chk("rst_fb", 10'h008, fb);
        chk("rst_ref", 10'h001, {3'h0, rdiv});
        chk("rst_pmode", 10'h000, {9'h000, pmode});
        chk("rst_oe_n", 10'h001, {9'h000, dev_oe_n});
        chk("data_pin", 10'h000, {9'h000, dev_data});
        cyc(1);
        i_sys_rst = 1'b0;
        cyc(45);
        chk("settled_early", 10'h000, {9'h000, settled});
        chk("pin_fb_hi", 10'h008, fb);
        chk("pin_ref", 10'h001, {3'h0, rdiv});
        cyc(10);
        chk("settled", 10'h001, {9'h000, settled});
        i_pll_mult_pin = 1'b0;
        i_clk_sel_pin = 1'b1;
        cyc(6);
        chk("pin_fb", 10'h010, fb);
        chk("bypass", 10'h001, {9'h000, byp});
        i_clk_sel_pin = 1'b0;
        cyc(6);
        chk("no_bypass", 10'h000, {9'h000, byp});
        for (int k = 0; k < 4; k++) begin
            wr_cfg(cfg[k][0], cfg[k][1], cfg[k][2]);
            cyc(20);
            if (cfg[k][0][6]) begin
                chk("fb", ({2'h0, cfg[k][1]} + 10'h003) << 1, fb);
                chk("ref", cfg[k][0][7] ? 10'h001 : {4'h0, cfg[k][0][5:0]} + 10'h002,
                    {3'h0, rdiv});
            end else begin
                chk("fb", 10'h010, fb);
                chk("ref", 10'h001, {3'h0, rdiv});
            end
            chk("pmode", {9'h000, cfg[k][0][6]}, {9'h000, pmode});
        end
        for (int k = 0; k < 2; k++) begin
            mst.start_cond();
            mst.wr_byte(k ? 8'h4a : 8'hc8, a);
            chk("foreign_ack", 10'h001, {9'h000, a});
            mst.wr_byte(8'h45, a);
            chk("foreign_data", 10'h001, {9'h000, a});
            mst.stop_cond();
        end
        cyc(20);
        chk("foreign_fb", 10'h010, fb);
        mst.start_cond();
        mst.wr_byte(8'hcb, a);
        chk("rd_addr_ack", 10'h000, {9'h000, a});
        for (int k = 0; k < 4; k++) begin
            mst.rd_byte(k == 3, rb);
            chk("rd_byte", {2'h0, k < 3 ? cfg[3][k] : 8'h00}, {2'h0, rb});
        end
        mst.stop_cond();
        cyc(4);
        chk("released", 10'h001, {9'h000, dev_oe_n});
        tally_and_finish();
    end

endmodule : tb_top
